// File: rtl/output_compare_pwm_channel.sv
// output compare and simple pwm channels with their register port
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module output_compare_pwm_channel #(
  parameter int N_CH = oc_pkg::NUM_CH
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  input  wire logic [15:0]          i_addr,
  input  wire logic [15:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  input  wire oc_pkg::timer_in_type i_timer_a,
  input  wire oc_pkg::timer_in_type i_timer_b,
  input  wire logic                 i_cpu_idle,
  input  wire logic                 i_cpu_sleep,
  input  wire logic [1:0]           i_fault_input_pin_n,
  output logic      [15:0]          o_rdata,
  output logic      [N_CH-1:0]      o_compare_output_pin,
  output logic      [N_CH-1:0]      o_compare_output_pin_oe,
  output logic      [N_CH-1:0]      o_compare_irq_flag,
  output logic      [1:0]           o_pwm_period_evt
);

  oc_pkg::reg_sel_type  sel;
  oc_pkg::mode_type     mode_r   [N_CH];
  logic [15:0]          prim_r   [N_CH];
  logic [15:0]          sec_r    [N_CH];
  logic [N_CH-1:0]      tsel_r;
  logic [N_CH-1:0]      halt_r;
  logic [N_CH-1:0]      fault_r;
  logic [N_CH-1:0]      armed_r;
  logic [N_CH-1:0]      run;
  logic [N_CH-1:0]      pri_hit;
  logic [N_CH-1:0]      sec_hit;
  logic [N_CH-1:0]      per_evt;
  logic [N_CH-1:0]      pwm_on;
  logic [N_CH-1:0]      cmp_evt;
  logic [N_CH-1:0]      ctrl_wr;
  logic [N_CH-1:0]      flag_clr;
  logic [N_CH-1:0]      per_on_a;
  logic [N_CH-1:0]      per_on_b;
  logic [1:0]           fault_ok;

  // one decoder shared by the write and read paths
  assign sel = oc_pkg::decode_addr(i_addr);

  // fault pins come from outside the clock domain
  oc_sync2 #(
    .WIDTH   (2),
    .RST_VAL (2'h3)
  ) u_fault_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (i_fault_input_pin_n),
    .o_sync  (fault_ok)
  );

  genvar g;
  generate
    for (g = 0; g < N_CH; g++)
    begin : g_ch
      oc_pkg::timer_in_type tm;
      logic                 flt_ok;
      logic                 wr_here;
      logic                 duty_eq;

      assign tm      = tsel_r[g] ? i_timer_b : i_timer_a;
      assign flt_ok  = (g < N_CH / 2) ? fault_ok[0] : fault_ok[1];
      assign wr_here = i_wr && sel.hit && (32'(sel.ch) == g);
      assign ctrl_wr[g] = wr_here && (sel.kind == oc_pkg::SEL_CTRL);
      assign flag_clr[g] = i_wr && sel.hit
                        && (sel.kind == oc_pkg::SEL_FLAGS) && i_wdata[g];

      // sleep freezes the compares and the pin; idle only when the bits allow it
      assign run[g] = !i_cpu_sleep
                   && !(i_cpu_idle && (halt_r[g] || !tm.on
                                       || tm.idle_stop));
      assign pwm_on[g] = (mode_r[g] == oc_pkg::MODE_PWM)
                      || (mode_r[g] == oc_pkg::MODE_PWM_FAULT);
      // the timer clears on the increment after it equals the period
      assign per_evt[g] = run[g] && pwm_on[g] && tm.inc
                       && (tm.count == tm.period);
      // fall on the increment that brings the count to the duty value, so
      // the high time equals the duty in timer ticks, not one tick more
      assign duty_eq    = tm.inc
                       && (16'(tm.count + 16'h0001) == prim_r[g]);
      assign per_on_a[g] = per_evt[g] && !tsel_r[g];
      assign per_on_b[g] = per_evt[g] && tsel_r[g];

      oc_match_detect u_pri (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_en    (run[g]),
        .i_count (tm.count),
        .i_value (prim_r[g]),
        .o_hit   (pri_hit[g])
      );

      oc_match_detect u_sec (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_en    (run[g]),
        .i_count (tm.count),
        .i_value (sec_r[g]),
        .o_hit   (sec_hit[g])
      );

      // compare events that raise the flag; none in pwm modes
      always_comb
      begin
        case (mode_r[g])
          oc_pkg::MODE_LOW,
          oc_pkg::MODE_HIGH,
          oc_pkg::MODE_TOGGLE:
            cmp_evt[g] = pri_hit[g];
          oc_pkg::MODE_ONE_PULSE:
            cmp_evt[g] = armed_r[g] && (pri_hit[g] || sec_hit[g]);
          oc_pkg::MODE_PULSE_TRAIN:
            cmp_evt[g] = pri_hit[g] || sec_hit[g];
          default:
            cmp_evt[g] = 1'b0;
        endcase
      end

      // control register fields; the fault bit is not writable
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_n)
        begin
          mode_r[g] <= oc_pkg::MODE_OFF;
          tsel_r[g] <= oc_pkg::RST_TSEL;
          halt_r[g] <= 1'b0;
        end
        else if (ctrl_wr[g])
        begin
          mode_r[g] <= oc_pkg::mode_type'(i_wdata[2:0]);
          tsel_r[g] <= i_wdata[oc_pkg::BIT_TSEL];
          halt_r[g] <= i_wdata[oc_pkg::BIT_HALT];
        end
      end

      // secondary is always writable and holds the buffered duty
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_n)
          sec_r[g] <= oc_pkg::RST_WORD;
        else if (wr_here && sel.kind == oc_pkg::SEL_SEC)
          sec_r[g] <= i_wdata;
      end

      // primary becomes the active duty latch in pwm modes
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_n)
          prim_r[g] <= oc_pkg::RST_WORD;
        else if (per_evt[g])
          prim_r[g] <= sec_r[g];
        else if (wr_here && sel.kind == oc_pkg::SEL_PRI && !pwm_on[g])
          prim_r[g] <= i_wdata;
      end

      // single pulse arms on each write of mode 100
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_n)
          armed_r[g] <= 1'b0;
        else if (ctrl_wr[g] && i_wdata[2:0] == oc_pkg::MODE_ONE_PULSE)
          armed_r[g] <= 1'b1;
        else if (mode_r[g] == oc_pkg::MODE_ONE_PULSE && sec_hit[g]
                 && o_compare_output_pin[g])
          armed_r[g] <= 1'b0;
      end

      // fault latch: a new fault wins over a clearing rewrite
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_n)
          fault_r[g] <= 1'b0;
        else if (mode_r[g] == oc_pkg::MODE_PWM_FAULT && !flt_ok)
          fault_r[g] <= 1'b1;
        else if (ctrl_wr[g] && i_wdata[2:1] == 2'h3 && flt_ok)
          fault_r[g] <= 1'b0;
      end

      // pin level; nothing moves while the channel is frozen
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_n)
          o_compare_output_pin[g] <= 1'b0;
        else if (run[g])
        begin
          case (mode_r[g])
            oc_pkg::MODE_OFF:
              o_compare_output_pin[g] <= 1'b0;
            oc_pkg::MODE_LOW:
              if (pri_hit[g])
                o_compare_output_pin[g] <= 1'b0;
            oc_pkg::MODE_HIGH:
              if (pri_hit[g])
                o_compare_output_pin[g] <= 1'b1;
            oc_pkg::MODE_TOGGLE:
              if (pri_hit[g])
                o_compare_output_pin[g] <= !o_compare_output_pin[g];
            oc_pkg::MODE_ONE_PULSE:
              if (armed_r[g] && pri_hit[g])
                o_compare_output_pin[g] <= 1'b1;
              else if (armed_r[g] && sec_hit[g])
                o_compare_output_pin[g] <= 1'b0;
            oc_pkg::MODE_PULSE_TRAIN:
              if (pri_hit[g])
                o_compare_output_pin[g] <= 1'b1;
              else if (sec_hit[g])
                o_compare_output_pin[g] <= 1'b0;
            default:
              // period boundary wins over a duty match in the same cycle
              if (per_evt[g])
                o_compare_output_pin[g] <= (sec_r[g] != 16'h0000);
              else if (duty_eq)
                o_compare_output_pin[g] <= 1'b0;
          endcase
        end
      end
      // a duty above the period never takes the pin low, so the pin stays high

      // drive only when enabled and not faulted
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_n)
          o_compare_output_pin_oe[g] <= 1'b0;
        else
          o_compare_output_pin_oe[g] <= (mode_r[g] != oc_pkg::MODE_OFF)
                                     && !fault_r[g];
      end

      // sticky compare flag; set beats a same-cycle clear
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_n)
          o_compare_irq_flag[g] <= 1'b0;
        else if (cmp_evt[g])
          o_compare_irq_flag[g] <= 1'b1;
        else if (flag_clr[g])
          o_compare_irq_flag[g] <= 1'b0;
      end
    end
  endgenerate

  // period events raise the owning timer's interrupt flag outside
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_pwm_period_evt <= 2'h0;
    else
      o_pwm_period_evt <= {|per_on_b, |per_on_a};
  end

  // read data appear the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_rdata <= oc_pkg::RST_WORD;
    else if (i_rd && sel.hit && (sel.kind == oc_pkg::SEL_FLAGS))
      o_rdata <= 16'(o_compare_irq_flag);
    else if (i_rd && sel.hit && (32'(sel.ch) < N_CH))
    begin
      case (sel.kind)
        oc_pkg::SEL_SEC:  o_rdata <= sec_r[sel.ch];
        oc_pkg::SEL_PRI:  o_rdata <= prim_r[sel.ch];
        oc_pkg::SEL_CTRL:
        begin
          o_rdata                    <= oc_pkg::RST_WORD;
          o_rdata[oc_pkg::BIT_HALT]  <= halt_r[sel.ch];
          o_rdata[oc_pkg::BIT_FAULT] <= fault_r[sel.ch];
          o_rdata[oc_pkg::BIT_TSEL]  <= tsel_r[sel.ch];
          o_rdata[2:0]               <= mode_r[sel.ch];
        end
        default:          o_rdata <= oc_pkg::RST_WORD;
      endcase
    end
    else
      o_rdata <= oc_pkg::RST_WORD;
  end

endmodule : output_compare_pwm_channel
`default_nettype wire

// File: rtl/oc_pkg.sv
// shared constants, types and address decode for the output compare block
`default_nettype none
package oc_pkg;

  // channel count and register placement
  localparam int          NUM_CH      = 8;
  localparam logic [15:0] ADDR_BASE   = 16'h0180;
  localparam logic [15:0] ADDR_STRIDE = 16'h0006;
  localparam logic [15:0] OFF_SEC     = 16'h0000;
  localparam logic [15:0] OFF_PRI     = 16'h0002;
  localparam logic [15:0] OFF_CTRL    = 16'h0004;
  localparam logic [15:0] ADDR_FLAGS  = 16'h01B0;

  // control register field positions
  localparam int BIT_HALT  = 13;
  localparam int BIT_FAULT = 4;
  localparam int BIT_TSEL  = 3;

  // values after reset; the fault latch resets to 0, RST_FAULT is unused
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic        RST_TSEL  = 1'b0;
  localparam logic        RST_FAULT = 1'b1;

  typedef enum logic [2:0] {
    MODE_OFF         = 3'b000,
    MODE_LOW         = 3'b001,
    MODE_HIGH        = 3'b010,
    MODE_TOGGLE      = 3'b011,
    MODE_ONE_PULSE   = 3'b100,
    MODE_PULSE_TRAIN = 3'b101,
    MODE_PWM         = 3'b110,
    MODE_PWM_FAULT   = 3'b111
  } mode_type;

  typedef enum logic [1:0] {
    SEL_SEC   = 2'b00,
    SEL_PRI   = 2'b01,
    SEL_CTRL  = 2'b10,
    SEL_FLAGS = 2'b11
  } reg_kind_type;

  // one time base as seen by the channels
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic        inc;
    logic        on;
    logic        idle_stop;
  } timer_in_type;

  typedef struct packed {
    logic         hit;
    logic [2:0]   ch;
    reg_kind_type kind;
  } reg_sel_type;

  // map a register port address onto channel and register kind
  function automatic reg_sel_type decode_addr(input logic [15:0] addr);
    logic [15:0] off;
    logic [15:0] idx;
    logic [15:0] rem;
    reg_sel_type s;
    off    = addr - ADDR_BASE;
    idx    = off / ADDR_STRIDE;
    rem    = off - 16'(idx * ADDR_STRIDE);
    s.hit  = 1'b0;
    s.ch   = 3'h0;
    s.kind = SEL_SEC;
    if (addr == ADDR_FLAGS)
    begin
      s.hit  = 1'b1;
      s.kind = SEL_FLAGS;
    end
    else if (addr >= ADDR_BASE && idx < 16'(NUM_CH))
    begin
      s.ch  = idx[2:0];
      s.hit = 1'b1;
      case (rem)
        OFF_SEC:  s.kind = SEL_SEC;
        OFF_PRI:  s.kind = SEL_PRI;
        OFF_CTRL: s.kind = SEL_CTRL;
        default:  s.hit  = 1'b0;
      endcase
    end
    return s;
  endfunction : decode_addr

endpackage : oc_pkg
`default_nettype wire

// File: rtl/oc_sync2.sv
// two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module oc_sync2 #(
  parameter int         WIDTH   = 2,
  parameter logic [1:0] RST_VAL = 2'h3
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      meta_r <= WIDTH'(RST_VAL);
      o_sync <= WIDTH'(RST_VAL);
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : oc_sync2
`default_nettype wire

// File: rtl/oc_match_detect.sv
// first-cycle equality detector between a timer count and a compare value
`timescale 1ns/1ps
`default_nettype none
module oc_match_detect (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_en,
  input  wire logic [15:0] i_count,
  input  wire logic [15:0] i_value,
  output logic             o_hit
);

  logic eq_r;
  logic eq;

  assign eq = (i_count == i_value);

  // one pulse per arrival at the value; a count that stays put or a
  // timer that wraps early before reaching it gives no pulse
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      eq_r  <= 1'b0;
      o_hit <= 1'b0;
    end
    else if (i_en)
    begin
      eq_r  <= eq;
      o_hit <= eq && !eq_r;
    end
    else
    begin
      o_hit <= 1'b0;
    end
  end

endmodule : oc_match_detect
`default_nettype wire

// File: verification/output_compare_pwm_channel_asserts.sv
// assertion checker for the output compare register port and pins
`timescale 1ns/1ps
`default_nettype none
module output_compare_pwm_channel_chk #(
  parameter int N_CH = 8
) (
  input wire logic                 i_mclk,
  input wire logic                 i_rst_n,
  input wire logic [15:0]          i_addr,
  input wire logic [15:0]          i_wdata,
  input wire logic                 i_wr,
  input wire logic                 i_rd,
  input wire oc_pkg::timer_in_type i_timer_a,
  input wire oc_pkg::timer_in_type i_timer_b,
  input wire logic                 i_cpu_idle,
  input wire logic                 i_cpu_sleep,
  input wire logic [1:0]           i_fault_input_pin_n,
  input wire logic [15:0]          o_rdata,
  input wire logic [N_CH-1:0]      o_compare_output_pin,
  input wire logic [N_CH-1:0]      o_compare_output_pin_oe,
  input wire logic [N_CH-1:0]      o_compare_irq_flag,
  input wire logic [1:0]           o_pwm_period_evt
);
  default clocking cb_main @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // period event of the second timer, the pwm time base in the bench
  wire evt_b = i_timer_b.inc && (i_timer_b.count == i_timer_b.period);

  // read steps of the flag register and of an unmapped place
  sequence s_flag_rd;
    i_rd && (i_addr == oc_pkg::ADDR_FLAGS);
  endsequence
  sequence s_void_rd;
    i_rd && (i_addr == 16'h0100);
  endsequence

  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  AST_VOID_READ: assert property (s_void_rd |=> o_rdata == 16'h0000)
    else $error("unmapped read returned data");
  AST_FLAG_READ: assert property (s_flag_rd |=>
    o_rdata[N_CH-1:0] == $past(o_compare_irq_flag))
    else $error("flag read differs from flag outputs");
  // a flag may only fall after a clear write, never by itself
  AST_FLAG_STICKY: assert property (
    ((~o_compare_irq_flag & $past(o_compare_irq_flag)) != '0) |->
    $past(i_wr && (i_addr == oc_pkg::ADDR_FLAGS)))
    else $error("compare flag fell without a clear write");
  AST_SLEEP_HOLD: assert property ($past(i_cpu_sleep) |->
    $stable(o_compare_output_pin) && $stable(o_compare_output_pin_oe))
    else $error("pin moved during sleep");
  AST_IDLE_HOLD: assert property ($past(i_cpu_idle &&
    i_timer_a.idle_stop && i_timer_b.idle_stop) |->
    $stable(o_compare_output_pin))
    else $error("pin moved during halted idle");
  AST_PERIOD_EVT: assert property (o_pwm_period_evt[1] |->
    $past(evt_b) || $past(evt_b, 2) || $past(evt_b, 3))
    else $error("period event without a timer period match");
  // drive may drop only after a fault low or a control write
  AST_FAULT_FLOAT: assert property (
    $fell(o_compare_output_pin_oe[0]) |->
    !$past(i_fault_input_pin_n[0], 3) || !$past(i_fault_input_pin_n[0], 4) ||
    !$past(i_fault_input_pin_n[0], 5) || $past(i_wr) || $past(i_wr, 2))
    else $error("pin drive dropped without cause");
  COV_FLAG_RD: cover property (s_flag_rd);
endmodule : output_compare_pwm_channel_chk

bind output_compare_pwm_channel output_compare_pwm_channel_chk #(
  .N_CH(N_CH)
) i_output_compare_pwm_channel_chk (.i_mclk, .i_rst_n, .i_addr, .i_wdata,
  .i_wr, .i_rd, .i_timer_a, .i_timer_b, .i_cpu_idle, .i_cpu_sleep,
  .i_fault_input_pin_n, .o_rdata, .o_compare_output_pin,
  .o_compare_output_pin_oe, .o_compare_irq_flag, .o_pwm_period_evt);
`default_nettype wire

// File: verification/oc_far_end.sv
// pin load and fault source standing outside the compare channels
`timescale 1ns/1ps
`default_nettype none
module oc_far_end (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_pin,
  input  wire logic [7:0] i_oe,
  input  wire logic [1:0] i_fault_cmd,
  output logic      [1:0] o_fault_input_pin_n,
  output logic      [7:0] o_level
);
  logic [7:0] last_r;
  // fault lines idle high; a command bit pulls one low
  assign o_fault_input_pin_n = ~i_fault_cmd;
  // no pull on the pin, so a floated pin shows the inverse of its last level
  always_ff @(posedge i_mclk)
    last_r <= (i_pin & i_oe) | (last_r & ~i_oe);
  assign o_level = (i_pin & i_oe) | (~last_r & ~i_oe);
endmodule : oc_far_end
`default_nettype wire

// File: verification/tb_output_compare_pwm_channel.sv
// self-checking bench for the output compare block
`timescale 1ns/1ps
`default_nettype none
module tb_output_compare_pwm_channel;
  `define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
    error_cnt++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_cpu_idle = 1'b0;
  logic        i_cpu_sleep = 1'b0;
  logic        istop = 1'b0;
  logic [15:0] ca = 16'h0000;
  logic [15:0] cb = 16'h0000;
  logic [15:0] pa = 16'h0013;
  logic [15:0] pb = 16'h0009;
  logic [1:0]  fault_cmd = 2'h0;
  wire  [1:0]  fault_n;
  wire  [15:0] rdata;
  wire  [7:0]  pin;
  wire  [7:0]  oe;
  wire  [7:0]  flag;
  wire  [7:0]  level;
  wire  [1:0]  evt;
  wire  [9:0]  prb = {evt[1], oe[0], pin};
  oc_pkg::timer_in_type ta;
  oc_pkg::timer_in_type tb;
  int          error_cnt = 0;
  int          total_checks = 0;

  assign ta = {ca, pa, 1'b1, 1'b1, istop};
  assign tb = {cb, pb, 1'b1, 1'b1, istop};
  always #4 i_mclk = ~i_mclk;
  // timers advance every cycle and clear after reaching their period
  always @(posedge i_mclk)
  begin
    ca <= (ca == pa) ? 16'h0000 : ca + 16'h0001;
    cb <= (cb == pb) ? 16'h0000 : cb + 16'h0001;
  end

  output_compare_pwm_channel i_output_compare_pwm_channel (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_timer_a(ta), .i_timer_b(tb), .i_cpu_idle(i_cpu_idle),
    .i_cpu_sleep(i_cpu_sleep), .i_fault_input_pin_n(fault_n),
    .o_rdata(rdata), .o_compare_output_pin(pin),
    .o_compare_output_pin_oe(oe), .o_compare_irq_flag(flag),
    .o_pwm_period_evt(evt));
  oc_far_end i_oc_far_end (.i_mclk(i_mclk), .i_pin(pin), .i_oe(oe),
    .i_fault_cmd(fault_cmd), .o_fault_input_pin_n(fault_n),
    .o_level(level));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  function automatic logic [15:0] ad(input int c, input logic [15:0] off);
    return oc_pkg::ADDR_BASE + 16'(c) * oc_pkg::ADDR_STRIDE + off;
  endfunction : ad

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  // the answer stands only in the cycle after the read edge
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK("read data", e, rdata)
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : wt

  // bounded wait for one probe bit; running out ends the run
  task automatic wsig(input int k, input logic v);
    for (int i = 0; i < 300; i++)
    begin
      wt(1);
      if (prb[k] === v)
        return;
    end
    `CHK("wait probe", v, prb[k])
    give_verdict();
  endtask : wsig

  // high cycles and level changes seen on the loaded pin
  task automatic meas(input int c, input int n, output int h, output int e);
    logic last;
    h = 0;
    e = 0;
    last = level[c];
    repeat (n)
    begin
      wt(1);
      h += int'(level[c] === 1'b1);
      e += int'(level[c] !== last);
      last = level[c];
    end
  endtask : meas

  initial
  begin
    int h;
    int e;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (int c = 0; c < 8; c++)
      rd(ad(c, oc_pkg::OFF_CTRL), 16'h0000);
    rd(16'h0100, 16'h0000);
    // low, high, toggle on 1..3; channel 4 compares beyond the period
    for (int c = 1; c < 5; c++)
    begin
      wr(ad(c, oc_pkg::OFF_PRI), (c == 4) ? 16'h001E : 16'h000A);
      wr(ad(c, oc_pkg::OFF_CTRL), (c == 4) ? 16'h0002 : 16'(c));
    end
    rd(ad(2, oc_pkg::OFF_PRI), 16'h000A);
    wsig(2, 1'b1);
    meas(3, 40, h, e);
    `CHK("toggle edges", 2, e)
    `CHK("low pin", 1'b0, pin[1])
    `CHK("low flag", 1'b1, flag[1])
    `CHK("wrap pin", 1'b0, pin[4])
    `CHK("wrap flag", 1'b0, flag[4])
    // pulses from 4 to 8, period 19 covers the end; single pulse armed last
    for (int c = 6; c > 4; c--)
    begin
      wr(ad(c, oc_pkg::OFF_PRI), 16'h0004);
      wr(ad(c, oc_pkg::OFF_SEC), 16'h0008);
      wr(ad(c, oc_pkg::OFF_CTRL), 16'(c - 1));
    end
    meas(5, 60, h, e);
    `CHK("one pulse", 4, h)
    meas(6, 60, h, e);
    `CHK("pulse train", 12, h)
    wr(ad(5, oc_pkg::OFF_CTRL), 16'h0004);
    meas(5, 60, h, e);
    `CHK("re-armed pulse", 4, h)
    // all channels off, then the sticky flags are cleared
    for (int c = 0; c < 8; c++)
      wr(ad(c, oc_pkg::OFF_CTRL), 16'h0000);
    wr(oc_pkg::ADDR_FLAGS, 16'h00FF);
    rd(oc_pkg::ADDR_FLAGS, 16'h0000);
    `CHK("off oe", 8'h00, oe)
    `CHK("off pin", 8'h00, pin)
    // pwm of duty 3 on the second timer, period 9
    wr(ad(0, oc_pkg::OFF_SEC), 16'h0003);
    wr(ad(0, oc_pkg::OFF_CTRL), 16'h000E);
    wsig(9, 1'b1);
    `CHK("evt other timer", 1'b0, evt[0])
    meas(0, 40, h, e);
    `CHK("pwm high", 12, h)
    `CHK("pwm edges", 8, e)
    rd(ad(0, oc_pkg::OFF_PRI), 16'h0003);
    wr(ad(0, oc_pkg::OFF_PRI), 16'h0007);
    rd(ad(0, oc_pkg::OFF_PRI), 16'h0003);
    `CHK("pwm flag", 1'b0, flag[0])
    // duty zero keeps low, duty above the period keeps high
    for (int i = 0; i < 2; i++)
    begin
      wr(ad(0, oc_pkg::OFF_SEC), (i == 1) ? 16'h000F : 16'h0000);
      wt(25);
      meas(0, 20, h, e);
      `CHK("duty extreme", (i == 1) ? 20 : 0, h)
    end
    // fault floats the pin until released and the mode is rewritten
    wr(ad(0, oc_pkg::OFF_SEC), 16'h0003);
    wr(ad(0, oc_pkg::OFF_CTRL), 16'h000F);
    wt(12);
    fault_cmd <= 2'h1;
    wsig(8, 1'b0);
    rd(ad(0, oc_pkg::OFF_CTRL), 16'h001F);
    fault_cmd <= 2'h0;
    wt(10);
    `CHK("still floated", 1'b0, oe[0])
    wr(ad(0, oc_pkg::OFF_CTRL), 16'h000F);
    wt(2);
    `CHK("drive back", 1'b1, oe[0])
    rd(ad(0, oc_pkg::OFF_CTRL), 16'h000F);
    // sleep, then halted idle, freeze the toggle channel
    wr(ad(3, oc_pkg::OFF_CTRL), 16'h2003);
    // drive enable must be up before the freeze, it is not held by sleep
    wt(3);
    for (int i = 0; i < 2; i++)
    begin
      i_cpu_sleep <= (i == 0);
      i_cpu_idle <= (i == 1);
      istop <= (i == 1);
      meas(3, 60, h, e);
      `CHK("frozen edges", 0, e)
      i_cpu_sleep <= 1'b0;
      i_cpu_idle <= 1'b0;
      meas(3, 40, h, e);
      `CHK("resumed edges", 2, e)
    end
    give_verdict();
  end
endmodule : tb_output_compare_pwm_channel
`default_nettype wire
